/* File: hdl/clr_ops_pkg.sv */
// Constants and carrier types for the register-clear and watchdog-clear unit.
// Assumes a core that runs a four-phase instruction cycle on one clock.
package clr_ops_pkg;

   // ****************************************************************
   // Instruction encodings
   // ****************************************************************
   localparam logic [15:0] CLR_REG_MASK   = 16'hFE00;
   localparam logic [15:0] CLR_REG_PATTERN = 16'h6A00;
   localparam int          ACCESS_SEL_BIT = 8;
   localparam logic [15:0] CLR_WDOG_WORD  = 16'h0004;
   localparam logic [7:0]  ILO_LIMIT      = 8'h5F;
   localparam logic [7:0]  ACCESS_SPLIT   = 8'h60;

   // ****************************************************************
   // Register map, byte addresses on the bus
   // ****************************************************************
   localparam logic [7:0] CTRL_OFS     = 8'h00;
   localparam logic [7:0] BANK_OFS     = 8'h04;
   localparam logic [7:0] INDEX_OFS    = 8'h08;
   localparam logic [7:0] STATUS_OFS   = 8'h0C;
   localparam logic [7:0] WDOG_OFS     = 8'h10;
   localparam logic [7:0] POST_OFS     = 8'h14;
   localparam logic [7:0] MEM_ADDR_OFS = 8'h18;
   localparam logic [7:0] MEM_DATA_OFS = 8'h1C;

   // ****************************************************************
   // Field positions and reset values
   // ****************************************************************
   localparam int         CTRL_EXT_BIT   = 0;
   localparam int         STAT_Z_BIT     = 0;
   localparam int         STAT_PWRDN_BIT = 1;
   localparam int         STAT_TMO_BIT   = 2;
   localparam logic       TMO_RESET      = 1'b1;
   localparam logic       PWRDN_RESET    = 1'b1;
   localparam int         ADDR_W         = 12;
   localparam int         DATA_BANK_W    = 4;
   localparam int         WDOG_W         = 8;
   localparam int         POST_W         = 8;

   typedef enum logic [1:0] {
      PH_DECODE,
      PH_READ,
      PH_PROCESS,
      PH_WRITE
   } phase_type;

   typedef struct packed {
      logic       valid;
      logic       is_clr_reg;
      logic       is_clr_wdog;
      logic       access_sel;
      logic [7:0] file_addr;
   } decoded_type;

endpackage

/* File: hdl/clear_reg_and_watchdog_ops.sv */
// Execution unit for the register-clear and watchdog-clear instructions,
// with its data memory, watchdog counter and a classic Wishbone slave.
// Assumes instructions arrive synchronous to clk_i and are sampled at the
// decode phase of each four-phase instruction cycle.
`timescale 1ns/10ps

// Summary of operation
// [RULE_01] Register-clear is recognised by fixed upper seven bits, selector, address.
// [RULE_02] Register-clear writes zero into every bit of the target register.
// [RULE_03] Selector 0 uses the access bank; selector 1 uses bank_select_reg.
// [RULE_04] Selector 0, extended set, address up to 5Fh uses indexed offset.
// [RULE_05] Watchdog-clear resets the watchdog counter.
// [RULE_06] Watchdog-clear zeroes the postscaler and sets both low-active flags.
// [RULE_07] One word, one cycle; read in phase 2, process 3, write 4.
module clear_reg_and_watchdog_ops
   import clr_ops_pkg::*;
#(
   parameter int BANK_W = DATA_BANK_W
)
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic [15:0] instr_i,
   input  wire logic        instr_valid_i,
   output logic [1:0]       phase_o,
   output logic             exec_done_o,
   output logic             timeout_flag_n_o,
   output logic             powerdown_flag_n_o,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o
);

   localparam int AW = BANK_W + 8;

   if (BANK_W < 1 || BANK_W > ADDR_W - 8)
   begin : g_bad_bank
      $error("BANK_W must lie between 1 and 4.");
   end

   // ****************************************************************
   // Decode
   // ****************************************************************
   function automatic decoded_type decode_instr(input logic [15:0] w,
                                                input logic        v);
      decoded_type d;
      d.valid      = v;
      d.is_clr_reg  = v && ((w & CLR_REG_MASK) == CLR_REG_PATTERN);
      d.is_clr_wdog = v && (w == CLR_WDOG_WORD);
      d.access_sel = w[ACCESS_SEL_BIT];
      d.file_addr  = w[7:0];
      return d;
   endfunction

   phase_type   phase_r,   phase_nxt;
   decoded_type dec_r,     dec_nxt;
   logic [AW-1:0] eff_r,   eff_nxt;
   logic [7:0]  clr_data_r, clr_data_nxt;
   logic        done_r,    done_nxt;
   logic        ext_en_r,  ext_en_nxt;
   logic [BANK_W-1:0] bank_select_reg_r, bank_select_reg_nxt;
   logic [AW-1:0] index_r, index_nxt;
   logic [AW-1:0] mem_ptr_r, mem_ptr_nxt;
   logic        z_r,       z_nxt;
   logic        to_n_r,    to_n_nxt;
   logic        pwrdn_n_r, pwrdn_n_nxt;
   logic [WDOG_W-1:0] watchdog_counter_r, watchdog_counter_nxt;
   logic [POST_W-1:0] post_r,    post_nxt;
   logic        ack_r,     ack_nxt;
   logic [31:0] rdata_r,   rdata_nxt;
   logic [7:0]  mem [0:(1<<AW)-1];
   logic        mem_we;
   logic [AW-1:0] mem_wa;
   logic [7:0]  mem_wd;
   logic        bus_wr;

   // ****************************************************************
   // Instruction cycle
   // ****************************************************************
   always_comb
   begin
      phase_nxt    = phase_r;
      dec_nxt      = dec_r;
      eff_nxt      = eff_r;
      clr_data_nxt = clr_data_r;
      done_nxt     = 1'b0;
      case (phase_r)
         PH_DECODE:
         begin
            phase_nxt = PH_READ;
            dec_nxt   = decode_instr(instr_i, instr_valid_i); // RULE_01
         end
         PH_READ:
         begin
            phase_nxt = PH_PROCESS;
            if (dec_r.access_sel)
               eff_nxt = {bank_select_reg_r, dec_r.file_addr}; // RULE_03
            else if (ext_en_r && dec_r.file_addr <= ILO_LIMIT)
               eff_nxt = index_r + AW'(dec_r.file_addr); // RULE_04
            else if (dec_r.file_addr < ACCESS_SPLIT)
               eff_nxt = {{BANK_W{1'b0}}, dec_r.file_addr}; // RULE_03
            else
               eff_nxt = {{BANK_W{1'b1}}, dec_r.file_addr}; // RULE_03
            clr_data_nxt = mem[eff_nxt];
         end
         PH_PROCESS:
         begin
            phase_nxt    = PH_WRITE;
            clr_data_nxt = 8'h00; // RULE_02
         end
         PH_WRITE:
         begin
            phase_nxt = PH_DECODE;
            done_nxt  = dec_r.valid; // RULE_07
         end
         default:
            phase_nxt = PH_DECODE;
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         phase_r    <= PH_DECODE;
         dec_r      <= '0;
         eff_r      <= '0;
         clr_data_r <= 8'h00;
         done_r     <= 1'b0;
      end
      else
      begin
         phase_r    <= phase_nxt;
         dec_r      <= dec_nxt;
         eff_r      <= eff_nxt;
         clr_data_r <= clr_data_nxt;
         done_r     <= done_nxt;
      end
   end

   // ****************************************************************
   // Data memory
   // ****************************************************************
   // The instruction write wins a clash with a bus write to memory, so
   // software sees a lost write rather than a half-executed instruction.
   assign bus_wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_r;

   always_comb
   begin
      mem_we = 1'b0;
      mem_wa = mem_ptr_r;
      mem_wd = wb_dat_i[7:0];
      if (phase_r == PH_WRITE && dec_r.is_clr_reg)
      begin
         mem_we = 1'b1; // RULE_07
         mem_wa = eff_r;
         mem_wd = clr_data_r; // RULE_02
      end
      else if (bus_wr && wb_adr_i == MEM_DATA_OFS && wb_sel_i[0])
         mem_we = 1'b1;
   end

   always_ff @(posedge clk_i)
   begin
      if (mem_we)
         mem[mem_wa] <= mem_wd;
   end

   // ****************************************************************
   // Watchdog, status and bus registers
   // ****************************************************************
   always_comb
   begin
      watchdog_counter_nxt = watchdog_counter_r;
      post_nxt             = post_r;
      to_n_nxt             = to_n_r;
      pwrdn_n_nxt          = pwrdn_n_r;
      z_nxt                = z_r;
      ext_en_nxt           = ext_en_r;
      bank_select_reg_nxt  = bank_select_reg_r;
      index_nxt            = index_r;
      mem_ptr_nxt          = mem_ptr_r;
      ack_nxt              = wb_cyc_i && wb_stb_i && !ack_r;
      rdata_nxt            = 32'h0000_0000;
      if (phase_r == PH_WRITE)
      begin
         watchdog_counter_nxt = watchdog_counter_r + WDOG_W'(1);
         if (&watchdog_counter_r)
            post_nxt = post_r + POST_W'(1);
      end
      if (bus_wr && wb_sel_i[0])
      begin
         case (wb_adr_i)
            CTRL_OFS:     ext_en_nxt = wb_dat_i[CTRL_EXT_BIT];
            BANK_OFS:     bank_select_reg_nxt = wb_dat_i[BANK_W-1:0];
            INDEX_OFS:    index_nxt = wb_dat_i[AW-1:0];
            STATUS_OFS:   z_nxt = wb_dat_i[STAT_Z_BIT];
            MEM_ADDR_OFS: mem_ptr_nxt = wb_dat_i[AW-1:0];
            default:      ;
         endcase
      end
      // Hardware events come last so that they win over a software clear.
      if (phase_r == PH_WRITE && dec_r.is_clr_reg)
         z_nxt = 1'b1;
      if (phase_r == PH_PROCESS && dec_r.is_clr_wdog)
      begin
         watchdog_counter_nxt = '0; // RULE_05
         post_nxt             = '0; // RULE_06
         to_n_nxt             = 1'b1; // RULE_06
         pwrdn_n_nxt          = 1'b1; // RULE_06
      end
      if (wb_cyc_i && wb_stb_i && !wb_we_i && !ack_r)
      begin
         case (wb_adr_i)
            CTRL_OFS:     rdata_nxt[CTRL_EXT_BIT] = ext_en_r;
            BANK_OFS:     rdata_nxt[BANK_W-1:0] = bank_select_reg_r;
            INDEX_OFS:    rdata_nxt[AW-1:0] = index_r;
            STATUS_OFS:   rdata_nxt[STAT_TMO_BIT:0] = {to_n_r, pwrdn_n_r, z_r};
            WDOG_OFS:     rdata_nxt[WDOG_W-1:0] = watchdog_counter_r;
            POST_OFS:     rdata_nxt[POST_W-1:0] = post_r;
            MEM_ADDR_OFS: rdata_nxt[AW-1:0] = mem_ptr_r;
            MEM_DATA_OFS: rdata_nxt[7:0] = mem[mem_ptr_r];
            default:      rdata_nxt = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         watchdog_counter_r <= '0;
         post_r             <= '0;
         to_n_r             <= TMO_RESET;
         pwrdn_n_r          <= PWRDN_RESET;
         z_r                <= 1'b0;
         ext_en_r           <= 1'b0;
         bank_select_reg_r  <= '0;
         index_r            <= '0;
         mem_ptr_r          <= '0;
         ack_r              <= 1'b0;
         rdata_r            <= 32'h0000_0000;
      end
      else
      begin
         watchdog_counter_r <= watchdog_counter_nxt;
         post_r             <= post_nxt;
         to_n_r             <= to_n_nxt;
         pwrdn_n_r          <= pwrdn_n_nxt;
         z_r                <= z_nxt;
         ext_en_r           <= ext_en_nxt;
         bank_select_reg_r  <= bank_select_reg_nxt;
         index_r            <= index_nxt;
         mem_ptr_r          <= mem_ptr_nxt;
         ack_r              <= ack_nxt;
         rdata_r            <= rdata_nxt;
      end
   end

   assign phase_o            = phase_r;
   assign exec_done_o        = done_r;
   assign timeout_flag_n_o   = to_n_r;
   assign powerdown_flag_n_o = pwrdn_n_r;
   assign wb_ack_o           = ack_r;
   assign wb_dat_o           = rdata_r;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   property p_decode;
      @(posedge clk_i) disable iff (rst_i)
      phase_r == PH_DECODE && instr_valid_i
         && instr_i[15:9] == CLR_REG_PATTERN[15:9]
      |=> dec_r.is_clr_reg ##3 done_r;
   endproperty
   a_decode: assert property (p_decode) // RULE_01
      else $error("Register-clear pattern not decoded.");

   property p_clear;
      @(posedge clk_i) disable iff (rst_i)
      phase_r == PH_WRITE && dec_r.is_clr_reg
      |=> mem[$past(eff_r)] == 8'h00;
   endproperty
   a_clear: assert property (p_clear) // RULE_02
      else $error("Target register not cleared.");

   property p_bank;
      @(posedge clk_i) disable iff (rst_i)
      phase_r == PH_READ && dec_r.access_sel
      |=> eff_r == {$past(bank_select_reg_r), $past(dec_r.file_addr)};
   endproperty
   a_bank: assert property (p_bank) // RULE_03
      else $error("Banked address not taken from bank select.");

   property p_index;
      @(posedge clk_i) disable iff (rst_i)
      phase_r == PH_READ && !dec_r.access_sel && ext_en_r
         && dec_r.file_addr <= 8'h5F
      |=> eff_r == $past(index_r) + AW'($past(dec_r.file_addr));
   endproperty
   a_index: assert property (p_index) // RULE_04
      else $error("Indexed offset address wrong.");

   property p_wdog;
      @(posedge clk_i) disable iff (rst_i)
      phase_r == PH_PROCESS && dec_r.is_clr_wdog
      |=> watchdog_counter_r == '0 ##1 watchdog_counter_r == WDOG_W'(1);
   endproperty
   a_wdog: assert property (p_wdog) // RULE_05
      else $error("Watchdog counter not reset.");

   property p_flags;
      @(posedge clk_i) disable iff (rst_i)
      phase_r == PH_PROCESS && dec_r.is_clr_wdog
      |=> post_r == '0 && timeout_flag_n_o && powerdown_flag_n_o;
   endproperty
   a_flags: assert property (p_flags) // RULE_06
      else $error("Postscaler or status flags wrong after watchdog clear.");

   property p_cycle;
      @(posedge clk_i) disable iff (rst_i)
      phase_r == PH_DECODE |=> phase_r == PH_READ ##1 phase_r == PH_PROCESS
         ##1 phase_r == PH_WRITE ##1 phase_r == PH_DECODE;
   endproperty
   a_cycle: assert property (p_cycle) // RULE_07
      else $error("Instruction cycle is not four phases.");

   property p_ack;
      @(posedge clk_i) disable iff (rst_i)
      wb_cyc_i && wb_stb_i && !ack_r |=> wb_ack_o ##1 !wb_ack_o;
   endproperty
   a_ack: assert property (p_ack)
      else $error("Bus acknowledge not a single cycle.");

endmodule

/* File: dv/test_clear_reg_and_watchdog_ops.sv */
// Self-checking bench for the register-clear and watchdog-clear unit.
// Assumes the package and design files are compiled first.
`timescale 1ns/10ps
module test_clear_reg_and_watchdog_ops;
   import clr_ops_pkg::*;

   // ****************************************************************
   // Signals
   // ****************************************************************
   logic        clk_i;
   logic        rst_i;
   logic [15:0] instr_i;
   logic        instr_valid_i;
   logic [1:0]  phase_o;
   logic        exec_done_o;
   logic        timeout_flag_n_o;
   logic        powerdown_flag_n_o;
   logic        wb_cyc_i;
   logic        wb_stb_i;
   logic        wb_we_i;
   logic [7:0]  wb_adr_i;
   logic [3:0]  wb_sel_i;
   logic [31:0] wb_dat_i;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o;
   logic [31:0] rd;
   int          fail_count;
   int          checks_done;

   typedef struct packed {
      logic        a;
      logic        ext;
      logic [3:0]  bank;
      logic [11:0] base;
      logic [7:0]  f;
      logic [11:0] addr;
   } row_type;
   row_type rows [7];

   clear_reg_and_watchdog_ops u_dut (.clk_i(clk_i), .rst_i(rst_i),
      .instr_i(instr_i), .instr_valid_i(instr_valid_i), .phase_o(phase_o),
      .exec_done_o(exec_done_o), .timeout_flag_n_o(timeout_flag_n_o),
      .powerdown_flag_n_o(powerdown_flag_n_o), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o));

   // ****************************************************************
   // Tasks
   // ****************************************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                        input string what);
      checks_done++;
      if (seen !== exp)
      begin
         $display("BAD %s expected %h seen %h", what, exp, seen);
         fail_count++;
      end
   endtask

   task automatic close_out;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // The request is held until ack is seen; a missing ack ends the run.
   task automatic bus(input logic we, input logic [7:0] adr,
                      input logic [31:0] dat, output logic [31:0] q);
      int n;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= adr;
      wb_dat_i <= dat;
      n = 0;
      do
      begin
         @(negedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      if (n >= 20)
      begin
         $display("BAD bus_ack expected 1 seen 0");
         fail_count++;
         close_out();
      end
      q = wb_dat_o;
      @(posedge clk_i);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
      logic [31:0] d;
      bus(1'b1, adr, dat, d);
   endtask

   // Presents a word for the decode phase and checks the done pulse.
   task automatic issue(input logic [15:0] w, input logic v);
      int n;
      n = 0;
      do
      begin
         @(negedge clk_i);
         n++;
      end while (phase_o !== 2'd3 && n < 8);
      if (n >= 8)
      begin
         $display("BAD phase expected 3 seen %0d", phase_o);
         fail_count++;
         close_out();
      end
      @(posedge clk_i);
      instr_i       <= w;
      instr_valid_i <= v;
      @(posedge clk_i);
      instr_valid_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      #1;
      check(32'(exec_done_o), 32'(v), "exec_done");
      check(32'(phase_o), 32'h0, "phase");
   endtask

   task automatic preset(input logic [11:0] adr, input logic [7:0] val);
      wr(MEM_ADDR_OFS, 32'(adr));
      wr(MEM_DATA_OFS, 32'(val));
   endtask

   task automatic mem_chk(input logic [11:0] adr, input logic [7:0] exp);
      wr(MEM_ADDR_OFS, 32'(adr));
      bus(1'b0, MEM_DATA_OFS, 32'h0, rd);
      check({24'h0, rd[7:0]}, 32'(exp), "memory");
   endtask

   // ****************************************************************
   // Clock and sequence
   // ****************************************************************
   initial
   begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end

   initial
   begin
      rst_i = 1'b1;
      instr_i = 16'h0000;
      instr_valid_i = 1'b0;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i = 1'b0;
      wb_adr_i = 8'h00;
      wb_sel_i = 4'hF;
      wb_dat_i = 32'h0;
      fail_count = 0;
      checks_done = 0;
      rows[0] = {1'b0, 1'b0, 4'h0, 12'h000, 8'h10, 12'h010};
      rows[1] = {1'b0, 1'b0, 4'h5, 12'h000, 8'h80, 12'hF80};
      rows[2] = {1'b1, 1'b0, 4'h3, 12'h000, 8'h22, 12'h322};
      rows[3] = {1'b0, 1'b1, 4'h0, 12'h200, 8'h5F, 12'h25F};
      rows[4] = {1'b0, 1'b1, 4'h0, 12'h200, 8'h60, 12'hF60};
      rows[5] = {1'b1, 1'b1, 4'h2, 12'h200, 8'h05, 12'h205};
      rows[6] = {1'b0, 1'b1, 4'h0, 12'h300, 8'h00, 12'h300};
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      #1;
      check(32'(timeout_flag_n_o), 32'h1, "timeout_flag_n");
      check(32'(powerdown_flag_n_o), 32'h1, "powerdown_flag_n");
      check(32'(wb_ack_o), 32'h0, "ack");
      bus(1'b0, CTRL_OFS, 32'h0, rd);
      check(rd, 32'h0, "ctrl_reset");
      bus(1'b0, 8'h40, 32'h0, rd);
      check(rd, 32'h0, "unmapped");
      $display("reset and bus test done");
      for (int i = 0; i < 7; i++)
      begin
         wr(CTRL_OFS, 32'(rows[i].ext));
         wr(BANK_OFS, 32'(rows[i].bank));
         wr(INDEX_OFS, 32'(rows[i].base));
         preset(rows[i].addr, 8'h5A);
         preset(rows[i].addr + 12'h001, 8'hA5);
         wr(STATUS_OFS, 32'h0);
         issue({7'b0110101, rows[i].a, rows[i].f}, 1'b1);
         mem_chk(rows[i].addr, 8'h00);
         mem_chk(rows[i].addr + 12'h001, 8'hA5);
         bus(1'b0, STATUS_OFS, 32'h0, rd);
         check(32'(rd[0]), 32'h1, "zero_flag");
         $display("row %0d done", i);
      end
      // A near-miss word and a bubble must leave memory alone; the selector-1 word 6B10 then clears it.
      wr(CTRL_OFS, 32'h0);
      wr(BANK_OFS, 32'h0);
      preset(12'h010, 8'h5A);
      issue(16'h6C10, 1'b1);
      mem_chk(12'h010, 8'h5A);
      issue(16'h6A10, 1'b0);
      mem_chk(12'h010, 8'h5A);
      issue(16'h6B10, 1'b1);
      mem_chk(12'h010, 8'h00);
      $display("encoding test done");
      // Long enough for the counter to wrap so the postscaler moves.
      repeat (1100) @(posedge clk_i);
      bus(1'b0, POST_OFS, 32'h0, rd);
      check(32'(rd != 32'h0), 32'h1, "postscaler_running");
      wr(STATUS_OFS, 32'h0);
      check(32'(timeout_flag_n_o), 32'h1, "flag_read_only");
      issue(CLR_WDOG_WORD, 1'b1);
      bus(1'b0, WDOG_OFS, 32'h0, rd);
      check(32'(rd <= 32'h2), 32'h1, "watchdog_counter");
      bus(1'b0, POST_OFS, 32'h0, rd);
      check(rd, 32'h0, "postscaler");
      bus(1'b0, STATUS_OFS, 32'h0, rd);
      check(32'(rd[2:1]), 32'h3, "status_flags");
      check(32'(powerdown_flag_n_o), 32'h1, "powerdown_flag_n");
      $display("watchdog test done");
      close_out();
   end
endmodule
